// [ecc_event_capture_counter.sv]
// module: event capture counter with axi4-lite register slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module ecc_event_capture_counter (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // event inputs
   input  wire logic [31:0] event_in,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // interrupt
   output logic             irq
);

   ecc_pkg::ecc_ctrl_t ctrl_r;
   ecc_pkg::ecc_irq_t  ist_r;
   ecc_pkg::ecc_irq_t  imask_r;
   ecc_pkg::ecc_irq_t  iset;
   logic [15:0]        presc_r;
   logic [15:0]        div_cnt_r;
   logic [15:0]        limit_r;
   logic [15:0]        limit_act_r;
   logic [15:0]        count_r;
   logic [15:0]        begin_r;
   logic [15:0]        end_r;
   logic [31:0]        prev_in_r;
   logic               running_r;
   logic               early_end_r;
   logic               aw_full_r;
   logic               w_full_r;
   logic [7:0]         aw_addr_r;
   logic [31:0]        w_data_r;
   logic [3:0]         w_strb_r;
   logic               wr_fire;
   logic [31:0]        wmask;
   logic               wr_ctrl;
   logic               wr_limit;
   logic               sw_reset;
   logic               presc_pulse;
   logic               tick;
   logic [4:0]         pri_ch;
   logic [4:0]         sec_ch;
   logic               pri_ev;
   logic               sec_ev;
   logic               begin_ev;
   logic               end_ev;
   logic               begin_fall;
   logic               gate_act;
   logic               run_now;
   logic               early_hit;
   logic               wrap;
   logic [31:0]        rd_data;
   logic               rd_ok;
   logic               wr_ok;

   function automatic logic edge_hit(input logic cur, input logic prv, input ecc_pkg::ecc_edge_t sel);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         ecc_pkg::event_edge_rising:  hit = cur & ~prv;
         ecc_pkg::event_edge_falling: hit = ~cur & prv;
         default:                     hit = cur ^ prv;
      endcase
      return hit;
   endfunction : edge_hit

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk, input logic [31:0] dat);
      return (old & ~msk) | (dat & msk);
   endfunction : merge

   // ---------------- axi4-lite write path
   assign s_axi_awready = ~aw_full_r;
   assign s_axi_wready  = ~w_full_r;
   assign wr_fire       = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign wmask         = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign wr_ctrl       = wr_fire & (aw_addr_r == ecc_pkg::ECC_OFS_CTRL);
   assign wr_limit      = wr_fire & (aw_addr_r == ecc_pkg::ECC_OFS_LIMIT);

   assign sw_reset = wr_fire & (aw_addr_r == ecc_pkg::ECC_OFS_CMD) & w_strb_r[0]
                     & w_data_r[ecc_pkg::ECC_CMD_RST_BIT];

   always_comb begin
      unique case (aw_addr_r)
         ecc_pkg::ECC_OFS_CTRL, ecc_pkg::ECC_OFS_PRESCALE, ecc_pkg::ECC_OFS_LIMIT, ecc_pkg::ECC_OFS_CMD,
         ecc_pkg::ECC_OFS_IRQ_STAT, ecc_pkg::ECC_OFS_IRQ_MASK, ecc_pkg::ECC_OFS_COUNT,
         ecc_pkg::ECC_OFS_BEGIN, ecc_pkg::ECC_OFS_END: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_fire) begin
            aw_full_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_full_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ecc_pkg::ECC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? ecc_pkg::ECC_RESP_OKAY : ecc_pkg::ECC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r  <= ecc_pkg::ECC_CTRL_RST;
         presc_r <= ecc_pkg::ECC_PRESC_RST;
         imask_r <= ecc_pkg::ECC_IRQ_RST;
      end else if (wr_fire) begin
         if (aw_addr_r == ecc_pkg::ECC_OFS_CTRL) begin
            ctrl_r      <= ecc_pkg::ecc_ctrl_t'(31'(merge(32'(ctrl_r), wmask, w_data_r)));
            ctrl_r.rsvd <= '0;
         end
         if (aw_addr_r == ecc_pkg::ECC_OFS_PRESCALE)
            presc_r <= 16'(merge({16'h0000, presc_r}, wmask, w_data_r));
         if (aw_addr_r == ecc_pkg::ECC_OFS_IRQ_MASK)
            imask_r <= ecc_pkg::ecc_irq_t'(3'(merge({29'h0, imask_r}, wmask, w_data_r)));
      end
   end

   // ---------------- prescaler and counting clock
   assign presc_pulse = (div_cnt_r == presc_r);

   always_ff @(posedge aclk) begin
      if (!aresetn || presc_pulse || sw_reset)
         div_cnt_r <= 16'h0000;
      else
         div_cnt_r <= div_cnt_r + 16'h0001;
   end

   assign tick = ctrl_r.enable & (ctrl_r.use_divided_clock ? presc_pulse : 1'b1);

   // ---------------- event detection
   // secondary channel select
   assign pri_ch = ctrl_r.pri_ch;
   assign sec_ch = ctrl_r.shared_event_input ? ctrl_r.pri_ch : ctrl_r.sec_ch;

   assign pri_ev = edge_hit(event_in[pri_ch], prev_in_r[pri_ch], ctrl_r.pri_edge);
   assign sec_ev = edge_hit(event_in[sec_ch], prev_in_r[sec_ch], ctrl_r.sec_edge);

   assign begin_ev   = ctrl_r.enable & ((ctrl_r.mode == ecc_pkg::count_until_end_mode) ? sec_ev : pri_ev);
   assign end_ev     = ctrl_r.enable & ((ctrl_r.mode == ecc_pkg::count_until_end_mode) ? pri_ev : sec_ev);
   assign begin_fall = (ctrl_r.mode == ecc_pkg::count_until_end_mode) ? ~event_in[sec_ch] : ~event_in[pri_ch];

   assign gate_act = event_in[pri_ch] ^ ctrl_r.gate_active_low;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         prev_in_r <= 32'h0000_0000;
      else
         prev_in_r <= event_in;
   end

   // ---------------- run state
   assign early_hit = (ctrl_r.mode == ecc_pkg::start_to_stop_mode) & early_end_r & begin_ev;

   always_comb begin
      unique case (ctrl_r.mode)
         ecc_pkg::free_running_mode: run_now = 1'b1;
         ecc_pkg::level_gated_mode:  run_now = gate_act;
         default:                    run_now = running_r;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_ctrl) begin
         running_r   <= 1'b0;
         early_end_r <= 1'b0;
      end else if (ctrl_r.mode == ecc_pkg::start_to_stop_mode) begin
         if (early_hit) begin
            running_r   <= 1'b0;
            early_end_r <= 1'b0;
         end else if (begin_ev && !running_r) begin
            running_r <= 1'b1;
         end else if (end_ev && running_r) begin
            running_r <= 1'b0;
         end else if (end_ev) begin
            early_end_r <= 1'b1;
         end
      end else if (ctrl_r.mode == ecc_pkg::count_until_end_mode) begin
         if (end_ev)
            running_r <= 1'b0;
         else if (sw_reset || !running_r && begin_ev)
            running_r <= 1'b1;
      end
   end

   // ---------------- counter and limit
   assign wrap = tick & run_now & (count_r == limit_act_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= 16'h0000;
      end else if (sw_reset) begin
         count_r <= 16'h0000;
      end else if (early_hit) begin
         count_r <= 16'h0001;
      end else if (wrap) begin
         count_r <= 16'h0000;
      end else if (tick && run_now) begin
         count_r <= count_r + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         limit_r     <= ecc_pkg::ECC_LIMIT_DFLT;
         limit_act_r <= ecc_pkg::ECC_LIMIT_DFLT;
      end else if (wr_ctrl && !w_data_r[ecc_pkg::ECC_KEEP_BIT]) begin
         limit_r     <= ecc_pkg::ECC_LIMIT_DFLT;
         limit_act_r <= ecc_pkg::ECC_LIMIT_DFLT;
      end else begin
         if (wr_limit)
            limit_r <= 16'(merge({16'h0000, limit_r}, wmask, w_data_r));
         if (sw_reset || wrap)
            limit_act_r <= limit_r;
      end
   end

   // ---------------- captures
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         begin_r <= 16'h0000;
         end_r   <= 16'h0000;
      end else if (early_hit) begin
         begin_r <= {15'h0000, begin_fall};
         end_r   <= 16'h0001;
      end else begin
         if (begin_ev)
            begin_r <= count_r;
         if (end_ev)
            end_r <= count_r;
      end
   end

   // ---------------- interrupts
   assign iset = '{overflow: wrap, end_cap: end_ev | early_hit, begin_cap: begin_ev};

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ist_r <= ecc_pkg::ECC_IRQ_RST;
      else if (wr_fire && aw_addr_r == ecc_pkg::ECC_OFS_IRQ_STAT && w_strb_r[0])
         ist_r <= (ist_r & ~ecc_pkg::ecc_irq_t'(w_data_r[2:0])) | iset;
      else
         ist_r <= ist_r | iset;
   end

   assign irq = |(ist_r & imask_r);

   // ---------------- axi4-lite read path
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
         ecc_pkg::ECC_OFS_CTRL:     rd_data = 32'(ctrl_r);
         ecc_pkg::ECC_OFS_PRESCALE: rd_data = {16'h0000, presc_r};
         ecc_pkg::ECC_OFS_LIMIT:    rd_data = {limit_act_r, limit_r};
         ecc_pkg::ECC_OFS_COUNT:    rd_data = {15'h0000, running_r, count_r};
         ecc_pkg::ECC_OFS_BEGIN:    rd_data = {16'h0000, begin_r};
         ecc_pkg::ECC_OFS_END:      rd_data = {16'h0000, end_r};
         ecc_pkg::ECC_OFS_CMD:      rd_data = 32'h0000_0000;
         ecc_pkg::ECC_OFS_IRQ_STAT: rd_data = {29'h0, ist_r};
         ecc_pkg::ECC_OFS_IRQ_MASK: rd_data = {29'h0, imask_r};
         default:                   rd_ok   = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= ecc_pkg::ECC_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_ok ? ecc_pkg::ECC_RESP_OKAY : ecc_pkg::ECC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- assertions
   sequence s_count_step;
      tick && run_now && !sw_reset && !early_hit && count_r != limit_act_r;
   endsequence

   sequence s_sts_begin;
      ctrl_r.mode == ecc_pkg::start_to_stop_mode && begin_ev && !early_end_r && !running_r && !wr_ctrl;
   endsequence

   sequence s_sts_end;
      ctrl_r.mode == ecc_pkg::start_to_stop_mode && running_r && end_ev && !wr_ctrl;
   endsequence

   a_free_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == ecc_pkg::free_running_mode && !wr_ctrl ##0 s_count_step |=> count_r == $past(count_r) + 16'h0001)
      else $error("free mode count did not step");

   a_wrap_to_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap && !sw_reset && !early_hit && !wr_ctrl |=> count_r == 16'h0000 && limit_act_r == $past(limit_r))
      else $error("wrap did not clear count or load limit");

   a_sw_reset_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      sw_reset |=> count_r == 16'h0000)
      else $error("software reset did not clear count");

   a_limit_deferred: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_limit && !wrap && !sw_reset |=> limit_act_r == $past(limit_act_r))
      else $error("new limit acted at once");

   a_begin_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      begin_ev && !early_hit |=> begin_r == $past(count_r))
      else $error("begin capture wrong");

   a_sts_start_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_sts_begin |=> running_r)
      else $error("start-to-stop begin did not start");

   a_sts_end_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_sts_end |=> !running_r)
      else $error("start-to-stop end did not stop");

   a_early_end_caps: assert property (@(posedge aclk) disable iff (!aresetn)
      early_hit && !sw_reset |=> end_r == 16'h0001 && count_r == 16'h0001 && !running_r)
      else $error("early end captures wrong");

   a_until_end_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == ecc_pkg::count_until_end_mode && end_ev && !wr_ctrl |=> !running_r)
      else $error("until-end mode kept running");

   a_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == ecc_pkg::level_gated_mode && !gate_act && !sw_reset |=> $stable(count_r))
      else $error("level mode counted with gate closed");

   a_prescale_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.use_divided_clock && !presc_pulse && !sw_reset && !early_hit |=> $stable(count_r))
      else $error("count moved between prescale pulses");

   a_limit_default: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctrl && !w_data_r[ecc_pkg::ECC_KEEP_BIT] |=> limit_act_r == ecc_pkg::ECC_LIMIT_DFLT)
      else $error("limit not defaulted");

endmodule : ecc_event_capture_counter

`default_nettype wire

// [ecc_event_capture_counter_tb_top.sv]
// testbench: event capture counter over its register bus and event inputs
`timescale 1ns/10ps
`default_nettype none

module ecc_event_capture_counter_tb_top;
   typedef struct {logic [1:0] pe; logic [1:0] se; logic lv0; logic [15:0] b;} ecc_row_t;

   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] event_in;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
   logic [31:0] wdata   = 32'h0000_0000, rdata, rd_v;
   logic [1:0]  bresp, rresp, resp_v;
   logic [15:0] c0;
   int          errors  = 0, cmp_count = 0;
   // early end rows: begin edge, end edge, level before begin, begin capture
   ecc_row_t    rows[4] = '{'{2'h0, 2'h0, 1'b0, 16'h0000}, '{2'h1, 2'h1, 1'b1, 16'h0001},
                            '{2'h2, 2'h2, 1'b0, 16'h0000}, '{2'h3, 2'h0, 1'b1, 16'h0001}};
   logic [39:0] rst_tbl[8] = '{40'h00_0000_0000, 40'h04_0000_0000, 40'h08_ffff_ffff, 40'h0c_0000_0000,
                               40'h10_0000_0000, 40'h14_0000_0000, 40'h1c_0000_0000, 40'h20_0000_0000};

   always #4 aclk = ~aclk;

   ecc_event_src ecc_event_src_i (.aclk(aclk), .event_in(event_in));

   ecc_event_capture_counter ecc_event_capture_counter_i (
      .aclk(aclk), .aresetn(aresetn), .event_in(event_in),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .irq(irq));

   task automatic check(input string n, input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ad;
      bit dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!dd && wready) begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      resp_v = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd_v   = rdata;
      resp_v = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic lvl(input int ch, input logic v);
      ecc_event_src_i.set_lvl(ch, v);
   endtask : lvl

   // counter moves or stands over a fixed span
   task automatic span(input string n, input logic run);
      logic [15:0] a;
      rd(ecc_pkg::ECC_OFS_COUNT);
      a = rd_v[15:0];
      repeat (20) @(posedge aclk);
      rd(ecc_pkg::ECC_OFS_COUNT);
      check(n, 32'(rd_v[15:0] != a), 32'(run));
      $display("test %s done", n);
   endtask : span

   // enabled control word, primary ch 3, secondary ch 9
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] pe, input logic [1:0] se,
                                       input logic [31:0] x);
      return x | {14'h0000, se, 5'h09, 5'h03, 1'b0, pe, m, 1'b1};
   endfunction : ctl

   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // watchdog: the tests need under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      summarize();
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wr(ecc_pkg::ECC_OFS_IRQ_MASK, 32'h0000_0002);
      foreach (rows[i]) begin
         lvl(9, 1'b0);
         lvl(3, rows[i].lv0);
         wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h1, rows[i].pe, rows[i].se, 32'h0));
         wr(ecc_pkg::ECC_OFS_IRQ_STAT, 32'h0000_0007);
         lvl(9, 1'b1);
         lvl(9, 1'b0);
         lvl(3, !rows[i].lv0);
         rd(ecc_pkg::ECC_OFS_BEGIN);
         check("begin", rd_v, {16'h0000, rows[i].b});
         rd(ecc_pkg::ECC_OFS_END);
         check("end", rd_v, 32'h0000_0001);
         rd(ecc_pkg::ECC_OFS_COUNT);
         check("count", rd_v, 32'h0000_0001);
         rd(ecc_pkg::ECC_OFS_IRQ_STAT);
         check("flags", rd_v, 32'h0000_0003);
         check("irq", 32'(irq), 32'h1);
         $display("test row %0d done", i);
      end
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 32'h0));
      span("free", 1'b1);
      lvl(3, 1'b1);
      span("free events", 1'b1);
      wr(ecc_pkg::ECC_OFS_CTRL, 32'h0);
      wr(ecc_pkg::ECC_OFS_CMD, 32'h1);
      rd(ecc_pkg::ECC_OFS_COUNT);
      check("sw reset", 32'(rd_v[15:0]), 32'h0);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 32'h0));
      wr(ecc_pkg::ECC_OFS_LIMIT, 32'h5);
      rd(ecc_pkg::ECC_OFS_LIMIT);
      check("limit pending", rd_v, 32'hffff_0005);
      wr(ecc_pkg::ECC_OFS_CMD, 32'h1);
      rd(ecc_pkg::ECC_OFS_LIMIT);
      check("limit active", rd_v, 32'h0005_0005);
      repeat (6) begin
         rd(ecc_pkg::ECC_OFS_COUNT);
         check("wrap", 32'(rd_v[15:0] <= 16'h0005), 32'h1);
      end
      rd(ecc_pkg::ECC_OFS_IRQ_STAT);
      check("overflow", 32'(rd_v[2]), 32'h1);
      wr(ecc_pkg::ECC_OFS_IRQ_MASK, 32'h4);
      check("irq ovf", 32'(irq), 32'h1);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 32'h0010_0000));
      rd(ecc_pkg::ECC_OFS_LIMIT);
      check("limit kept", rd_v, 32'h0005_0005);
      wr(ecc_pkg::ECC_OFS_CTRL, 32'h0);
      rd(ecc_pkg::ECC_OFS_LIMIT);
      check("limit dflt", rd_v, 32'hffff_ffff);
      wr(ecc_pkg::ECC_OFS_IRQ_STAT, 32'h7);
      check("irq clear", 32'(irq), 32'h0);
      $display("test limit done");
      wr(ecc_pkg::ECC_OFS_PRESCALE, 32'h3);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 32'h0008_0000));
      wr(ecc_pkg::ECC_OFS_CMD, 32'h1);
      rd(ecc_pkg::ECC_OFS_COUNT);
      c0 = rd_v[15:0];
      repeat (40) @(posedge aclk);
      rd(ecc_pkg::ECC_OFS_COUNT);
      check("divided", 32'((rd_v[15:0] - c0) inside {[9:12]}), 32'h1);
      lvl(3, 1'b0);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 32'h0));
      span("gate idle", 1'b0);
      lvl(3, 1'b1);
      span("gate high", 1'b1);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h3, 2'h0, 2'h0, 32'h20));
      span("gate low", 1'b0);
      lvl(3, 1'b0);
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h1, 2'h0, 2'h1, 32'h0004_0000));
      span("s2s idle", 1'b0);
      lvl(3, 1'b1);
      span("s2s run", 1'b1);
      lvl(3, 1'b0);
      span("s2s stop", 1'b0);
      rd(ecc_pkg::ECC_OFS_BEGIN);
      c0 = rd_v[15:0];
      rd(ecc_pkg::ECC_OFS_END);
      check("s2s end", 32'(rd_v[15:0] > c0), 32'h1);
      wr(ecc_pkg::ECC_OFS_END, 32'h1234);
      check("ro resp", 32'(resp_v), 32'(ecc_pkg::ECC_RESP_OKAY));
      c0 = rd_v[15:0];
      rd(ecc_pkg::ECC_OFS_END);
      check("ro end", 32'(rd_v[15:0]), 32'(c0));
      rd(8'h40);
      check("rresp", {30'h0, resp_v}, {30'h0, ecc_pkg::ECC_RESP_SLVERR});
      check("rdata", rd_v, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      check("bresp", {30'h0, resp_v}, {30'h0, ecc_pkg::ECC_RESP_SLVERR});
      wr(ecc_pkg::ECC_OFS_CTRL, ctl(2'h2, 2'h0, 2'h0, 32'h0));
      wr(ecc_pkg::ECC_OFS_CMD, 32'h1);
      span("til run", 1'b1);
      lvl(3, 1'b1);
      span("til stop", 1'b0);
      lvl(9, 1'b1);
      span("til begin", 1'b1);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_tbl[i]) begin
         rd(rst_tbl[i][39:32]);
         check("reset", rd_v, rst_tbl[i][31:0]);
      end
      check("irq reset", 32'(irq), 32'h0);
      $display("test reset done");
      summarize();
   end
endmodule : ecc_event_capture_counter_tb_top

`default_nettype wire

// [ecc_event_src.sv]
// event source model driving the input channels of one block
`timescale 1ns/10ps
`default_nettype none

module ecc_event_src (
   // clock
   input  wire logic  aclk,
   // channel levels
   output logic [31:0] event_in
);
   initial event_in = 32'h0000_0000;

   // one channel changes level just after an edge
   task automatic set_lvl(input int ch, input logic v);
      @(posedge aclk);
      event_in[ch] <= v;
   endtask : set_lvl
endmodule : ecc_event_src

`default_nettype wire

// [ecc_pkg.sv]
// package: register map, fields and constants of the event capture counter
package ecc_pkg;

   // register byte offsets
   localparam logic [7:0] ECC_OFS_CTRL     = 8'h00;
   localparam logic [7:0] ECC_OFS_PRESCALE = 8'h04;
   localparam logic [7:0] ECC_OFS_LIMIT    = 8'h08;
   localparam logic [7:0] ECC_OFS_COUNT    = 8'h0c;
   localparam logic [7:0] ECC_OFS_BEGIN    = 8'h10;
   localparam logic [7:0] ECC_OFS_END      = 8'h14;
   localparam logic [7:0] ECC_OFS_CMD      = 8'h18;
   localparam logic [7:0] ECC_OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ECC_OFS_IRQ_MASK = 8'h20;

   // widths, reset values, bit positions and response codes
   localparam int          ECC_CW           = 16;
   localparam int          ECC_NCH          = 32;
   localparam logic [15:0] ECC_LIMIT_DFLT   = 16'hffff;
   localparam logic [15:0] ECC_PRESC_RST    = 16'h0000;
   localparam logic [2:0]  ECC_IRQ_RST      = 3'h0;
   localparam int          ECC_CMD_RST_BIT  = 0;
   localparam int          ECC_KEEP_BIT     = 20;
   localparam logic [1:0]  ECC_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  ECC_RESP_SLVERR  = 2'h2;

   // capture modes
   typedef enum logic [1:0] {
      free_running_mode    = 2'h0,
      start_to_stop_mode   = 2'h1,
      count_until_end_mode = 2'h2,
      level_gated_mode     = 2'h3
   } ecc_mode_t;

   // event edge selections
   typedef enum logic [1:0] {
      event_edge_rising  = 2'h0,
      event_edge_falling = 2'h1,
      event_edge_any     = 2'h2,
      event_edge_spare   = 2'h3
   } ecc_edge_t;

   // control register layout, msb first
   typedef struct packed {
      logic [9:0] rsvd;
      logic       keep_limit_value;
      logic       use_divided_clock;
      logic       shared_event_input;
      ecc_edge_t  sec_edge;
      logic [4:0] sec_ch;
      logic [4:0] pri_ch;
      logic       gate_active_low;
      ecc_edge_t  pri_edge;
      ecc_mode_t  mode;
      logic       enable;
   } ecc_ctrl_t;

   localparam ecc_ctrl_t ECC_CTRL_RST = '0;

   // sticky event flags
   typedef struct packed {
      logic overflow;
      logic end_cap;
      logic begin_cap;
   } ecc_irq_t;

endpackage : ecc_pkg
